// [hw/fsio_top.sv]
// Fail outputs, pull-up control and heartbeat supervision with APB registers.
// Assumes the mode, watchdog and failure detectors live elsewhere on clk;
// the heartbeat pin is asynchronous and is synchronised here.
// Contract
// - Failure drives outputs, sets active flag
// - Watchdog, thermal, supply short, reset clamp
// - Control bit picks one or two watchdog failures
// - Off only when clear and failures gone
// - Watchdog case needs trigger and cleared bits
// - Activation regardless of fail-safe mode entry
// - All three together; first stays low
// - Second blinks 1.25 Hz half duty
// - Third PWM 100 Hz, 20 percent
// - Pull-ups depend on mode and disable
// - Second pin doubles as heartbeat input
// - Rising edge required every 240 us window
// - Supervision on at reset, bit disables
// - Missing edge sets flag, first/third on
// - No mode change, reset, interrupt
// - Flag clear needs new rising edge
// - Supervision only in Normal mode
// - Filter suppresses pulses under 1.5 us
// - Watchdog reset sets watchdog failure bits
`timescale 1ns/1ns
module fsio_top
   import fsio_pkg::*;
#(
   parameter int unsigned HB_WINDOW  = HB_WINDOW_CYC,
   parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
   parameter int unsigned PWM_PERIOD = PWM_PERIOD_CYC,
   parameter int unsigned PWM_LOW    = PWM_LOW_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire fsio_pkg::fsio_mode_type mode,
   input  wire logic                   watchdog_failure_bits_event,
   input  wire logic                   wd_trigger_ok,
   input  wire logic                   thermal_shutdown_level2,
   input  wire logic                   main_regulator_short,
   input  wire logic                   reset_output_clamped,
   input  wire logic                   safety_heartbeat_in,
   output logic                        fail_out_static_oe,
   output logic                        fail_out_blink_oe,
   output logic                        fail_out_dim_pwm_oe,
   output logic                        fail_out_static_pu,
   output logic                        fail_out_blink_pu,
   output logic                        fail_out_dim_pwm_pu
);
   import fsio_pkg::*;

   // Refused at elaboration: the counters cannot serve these values
   if (HB_WINDOW < 2 || BLINK_HALF < 1 || PWM_LOW < 1 || PWM_LOW >= PWM_PERIOD) begin : g_bad_timing
      $error("fsio_top: unusable timing parameters");
   end

   logic [1:0]  hardware_control_reg_r;
   logic        fail_outputs_active_flag_r;
   logic        heartbeat_missing_flag_r;
   logic [1:0]  watchdog_failure_bits_r;
   logic        wd_served_r;
   logic        fo_active_r;
   logic        hb_meta_r;
   logic        hb_sync_r;
   logic        hb_filt_r;
   logic        hb_filt_d_r;
   logic [7:0]  hb_flt_cnt_r;
   logic [31:0] win_cnt_r;
   logic        hb_edge_since_fail_r;
   logic [31:0] blink_cnt_r;
   logic        blink_lvl_r;
   logic [31:0] pwm_cnt_r;
   logic        wr_en;
   logic        rd_en;
   logic        hb_rise;
   logic        hb_dis;
   logic        hb_active;
   logic        wd_cond;
   logic        fail_cond;
   logic        wd_hold;
   logic        fo_clear_req;
   logic        hb_clear_req;

   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign hb_dis  = hardware_control_reg_r[CT_HB_DIS];
   assign hb_rise = hb_filt_r && !hb_filt_d_r;
   assign hb_active = !hb_dis && (mode == MODE_NORMAL);
   // One failure or, with the select bit, a second one counted in the bits
   assign wd_cond = hardware_control_reg_r[CT_WD_CNT_SEL] ? watchdog_failure_bits_r[1]
                                              : watchdog_failure_bits_r[0];
   assign fail_cond = wd_cond || thermal_shutdown_level2 || main_regulator_short
                      || reset_output_clamped;
   // Watchdog-caused activation holds until serviced and the bits are cleared
   assign wd_hold = (watchdog_failure_bits_r != 2'h0) || !wd_served_r;
   assign fo_clear_req = wr_en && (paddr == ADDR_DEVICE_STATUS_REG) && pwdata[ST_FO_ON];
   assign hb_clear_req = wr_en && (paddr == ADDR_DEVICE_STATUS_REG) && pwdata[ST_HB_MISS];

   // APB: zero wait states, read data prepared in setup phase
   always_ff @(posedge clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && (paddr != ADDR_DEVICE_STATUS_REG) && (paddr != ADDR_HARDWARE_CONTROL_REG)
                    && (paddr != ADDR_FAIL_IN);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         if (paddr == ADDR_DEVICE_STATUS_REG) begin
            prdata <= {28'h0000000, watchdog_failure_bits_r, heartbeat_missing_flag_r,
                       fail_outputs_active_flag_r};
         end else if (paddr == ADDR_HARDWARE_CONTROL_REG) begin
            prdata <= {30'h00000000, hardware_control_reg_r};
         end else if (paddr == ADDR_FAIL_IN) begin
            prdata <= {29'h00000000, reset_output_clamped, main_regulator_short,
                       thermal_shutdown_level2};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hardware_control_reg_r <= HARDWARE_CONTROL_REG_RESET;
      end else if (wr_en && paddr == ADDR_HARDWARE_CONTROL_REG) begin
         hardware_control_reg_r <= pwdata[1:0];
      end
   end

   // Watchdog failure count; set wins over a software clear
   always_ff @(posedge clk) begin
      if (reset) begin
         watchdog_failure_bits_r <= 2'h0;
      end else if (watchdog_failure_bits_event) begin
         watchdog_failure_bits_r <= {watchdog_failure_bits_r[0], 1'b1};
      end else if (wr_en && paddr == ADDR_DEVICE_STATUS_REG && pwdata[ST_WATCHDOG_FAILURE_BITS_LO]) begin
         watchdog_failure_bits_r <= 2'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wd_served_r <= 1'b1;
      end else if (watchdog_failure_bits_event) begin
         wd_served_r <= 1'b0;
      end else if (wd_trigger_ok) begin
         wd_served_r <= 1'b1;
      end
   end

   // Flag and outputs; a standing failure keeps both set
   always_ff @(posedge clk) begin
      if (reset) begin
         fail_outputs_active_flag_r <= 1'b0;
      end else if (fail_cond) begin
         fail_outputs_active_flag_r <= 1'b1;
      end else if (fo_clear_req && !wd_hold) begin
         fail_outputs_active_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fo_active_r <= 1'b0;
      end else if (fail_cond) begin
         fo_active_r <= 1'b1;
      end else if (!fail_outputs_active_flag_r) begin
         fo_active_r <= 1'b0;
      end
   end

   // Heartbeat pin: two-stage synchroniser then a glitch filter
   always_ff @(posedge clk) begin
      if (reset) begin
         hb_meta_r <= 1'b1;
         hb_sync_r <= 1'b1;
      end else begin
         hb_meta_r <= safety_heartbeat_in;
         hb_sync_r <= hb_meta_r;
      end
   end

   // A new level is accepted after it stands stable for the filter time
   always_ff @(posedge clk) begin
      if (reset) begin
         hb_flt_cnt_r <= 8'h00;
         hb_filt_r    <= 1'b1;
      end else if (hb_sync_r == hb_filt_r) begin
         hb_flt_cnt_r <= 8'h00;
      end else if (hb_flt_cnt_r == 8'(HB_FILTER_CYC - 1)) begin
         hb_flt_cnt_r <= 8'h00;
         hb_filt_r    <= hb_sync_r;
      end else begin
         hb_flt_cnt_r <= hb_flt_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hb_filt_d_r <= 1'b1;
      end else begin
         hb_filt_d_r <= hb_filt_r;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !hb_active || hb_rise) begin
         win_cnt_r <= 32'h0000_0000;
      end else if (win_cnt_r != HB_WINDOW) begin
         win_cnt_r <= win_cnt_r + 32'h0000_0001;
      end
   end

   // Missing edge only raises the flag; mode, reset and interrupt untouched
   always_ff @(posedge clk) begin
      if (reset) begin
         heartbeat_missing_flag_r <= 1'b0;
      end else if (hb_active && win_cnt_r == HB_WINDOW - 1 && !hb_rise) begin
         heartbeat_missing_flag_r <= 1'b1;
      end else if (hb_clear_req && hb_edge_since_fail_r) begin
         heartbeat_missing_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         hb_edge_since_fail_r <= 1'b0;
      end else if (hb_active && win_cnt_r == HB_WINDOW - 1 && !hb_rise) begin
         hb_edge_since_fail_r <= 1'b0;
      end else if (hb_rise) begin
         hb_edge_since_fail_r <= 1'b1;
      end
   end

   // Blink restarts phase on activation, PWM when activation or heartbeat flag first turns it on
   always_ff @(posedge clk) begin
      if (reset || !fo_active_r) begin
         blink_cnt_r <= 32'h0000_0000;
         blink_lvl_r <= 1'b1;
      end else if (blink_cnt_r == BLINK_HALF - 1) begin
         blink_cnt_r <= 32'h0000_0000;
         blink_lvl_r <= !blink_lvl_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !(fo_active_r || heartbeat_missing_flag_r)) begin
         pwm_cnt_r <= 32'h0000_0000;
      end else if (pwm_cnt_r == PWM_PERIOD - 1) begin
         pwm_cnt_r <= 32'h0000_0000;
      end else begin
         pwm_cnt_r <= pwm_cnt_r + 32'h0000_0001;
      end
   end

   // Output enable high pulls the low-side pin down
   always_ff @(posedge clk) begin
      if (reset) begin
         fail_out_static_oe  <= 1'b0;
         fail_out_blink_oe   <= 1'b0;
         fail_out_dim_pwm_oe <= 1'b0;
      end else begin
         fail_out_static_oe  <= fo_active_r || heartbeat_missing_flag_r;
         fail_out_blink_oe   <= fo_active_r && blink_lvl_r;
         fail_out_dim_pwm_oe <= (fo_active_r || heartbeat_missing_flag_r)
                                && (pwm_cnt_r < PWM_LOW);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fail_out_static_pu  <= 1'b0;
         fail_out_blink_pu   <= 1'b0;
         fail_out_dim_pwm_pu <= 1'b0;
      end else begin
         fail_out_static_pu  <= (mode == MODE_INIT) || (mode == MODE_NORMAL);
         fail_out_blink_pu   <= ((mode == MODE_INIT) || (mode == MODE_NORMAL)) && !hb_dis;
         fail_out_dim_pwm_pu <= (mode == MODE_INIT);
      end
   end

   // Assertions
   sequence s_fail_seen;
      fail_cond;
   endsequence

   property p_flag_set;
      @(posedge clk) disable iff (reset) s_fail_seen |=> fail_outputs_active_flag_r;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set on failure");

   property p_static_on;
      @(posedge clk) disable iff (reset) fail_cond |-> ##2 fail_out_static_oe;
   endproperty
   a_static_on: assert property (p_static_on) else $error("static output not on");

   property p_wd_select;
      @(posedge clk) disable iff (reset)
         (watchdog_failure_bits_r == 2'h1 && !hardware_control_reg_r[CT_WD_CNT_SEL]) |=> fo_active_r;
   endproperty
   a_wd_select: assert property (p_wd_select) else $error("single wd failure ignored");

   property p_no_clear_fail;
      @(posedge clk) disable iff (reset) fail_cond |=> fail_outputs_active_flag_r;
   endproperty
   a_no_clear_fail: assert property (p_no_clear_fail) else $error("flag cleared in failure");

   property p_wd_hold;
      @(posedge clk) disable iff (reset)
         (fail_outputs_active_flag_r && wd_hold) |=> fail_outputs_active_flag_r;
   endproperty
   a_wd_hold: assert property (p_wd_hold) else $error("flag cleared before wd served");

   property p_hb_clear;
      @(posedge clk) disable iff (reset)
         (heartbeat_missing_flag_r && !hb_edge_since_fail_r && !hb_rise) |=> heartbeat_missing_flag_r;
   endproperty
   a_hb_clear: assert property (p_hb_clear) else $error("heartbeat flag cleared early");

   property p_hb_mode;
      @(posedge clk) disable iff (reset)
         (mode != MODE_NORMAL) && !heartbeat_missing_flag_r |=> !heartbeat_missing_flag_r;
   endproperty
   a_hb_mode: assert property (p_hb_mode) else $error("supervision outside Normal");

   property p_pu_dim;
      @(posedge clk) disable iff (reset)
         (mode == MODE_NORMAL) ##1 (mode == MODE_NORMAL) |-> !fail_out_dim_pwm_pu;
   endproperty
   a_pu_dim: assert property (p_pu_dim) else $error("dim pull-up in Normal");

   property p_filter;
      @(posedge clk) disable iff (reset)
         $changed(hb_filt_r) |-> $past(hb_sync_r, 1) == hb_filt_r;
   endproperty
   a_filter: assert property (p_filter) else $error("filter took unstable level");

   property p_hb_static;
      @(posedge clk) disable iff (reset) heartbeat_missing_flag_r |=> fail_out_static_oe;
   endproperty
   a_hb_static: assert property (p_hb_static) else $error("static off, beat lost");

   sequence s_fo_start;
      $rose(fo_active_r);
   endsequence

   property p_blink_start;
      @(posedge clk) disable iff (reset) s_fo_start |=> fail_out_blink_oe;
   endproperty
   a_blink_start: assert property (p_blink_start) else $error("blink not low first");

   property p_pwm_off;
      @(posedge clk) disable iff (reset) (pwm_cnt_r >= PWM_LOW) |=> !fail_out_dim_pwm_oe;
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("dim output on in off phase");

endmodule : fsio_top

// [hw/fsio_pkg.sv]
// Package for the fail output and heartbeat supervision block.
// Assumes a 100 MHz clock and an APB slave with 32-bit data.
package fsio_pkg;
   localparam int unsigned CLK_HZ            = 100_000_000;
   // Register byte addresses
   localparam logic [7:0]  ADDR_DEVICE_STATUS_REG     = 8'h00;
   localparam logic [7:0]  ADDR_HARDWARE_CONTROL_REG      = 8'h04;
   localparam logic [7:0]  ADDR_FAIL_IN      = 8'h08;
   // Status field positions
   localparam int unsigned ST_FO_ON          = 0;
   localparam int unsigned ST_HB_MISS        = 1;
   localparam int unsigned ST_WATCHDOG_FAILURE_BITS_LO     = 2;
   localparam int unsigned ST_WATCHDOG_FAILURE_BITS_HI     = 3;
   // Control field positions
   localparam int unsigned CT_WD_CNT_SEL     = 0;
   localparam int unsigned CT_HB_DIS         = 1;
   localparam logic [1:0]  HARDWARE_CONTROL_REG_RESET     = 2'h0;
   // Failure input positions
   localparam int unsigned FI_THERMAL_SHUTDOWN_LEVEL2           = 0;
   localparam int unsigned FI_VCC_SHORT      = 1;
   localparam int unsigned FI_RO_CLAMP       = 2;
   // Timing, printed figures and derived counts
   localparam int unsigned HB_FILTER_NS      = 1500;
   localparam int unsigned HB_WINDOW_US      = 240;
   localparam int unsigned BLINK_MHZ         = 1250;
   localparam int unsigned PWM_HZ            = 100;
   localparam int unsigned PWM_DUTY_PCT      = 20;
   localparam int unsigned HB_FILTER_CYC     = HB_FILTER_NS / 10;
   localparam int unsigned HB_WINDOW_CYC     = HB_WINDOW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BLINK_HALF_CYC    = (CLK_HZ / 2) / BLINK_MHZ * 1000;
   localparam int unsigned PWM_PERIOD_CYC    = CLK_HZ / PWM_HZ;
   localparam int unsigned PWM_LOW_CYC       = PWM_PERIOD_CYC * PWM_DUTY_PCT / 100;
   typedef enum logic [2:0] {
      MODE_INIT    = 3'b000,
      MODE_NORMAL  = 3'b001,
      MODE_STOP    = 3'b010,
      MODE_SLEEP   = 3'b011,
      MODE_RESTART = 3'b100,
      MODE_FAILSAFE= 3'b101
   } fsio_mode_type;
endpackage : fsio_pkg

// [tb/fsio_mcu_model.sv]
// Microcontroller heartbeat source on the shared second fail-output pin.
// Assumes the device pulls the pin low whenever its blink output is enabled.
`timescale 1ns/1ns
module fsio_mcu_model (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic        glitch,
   input  wire logic [15:0] half,
   input  wire logic        blink_oe,
   output logic             pin
);
   logic [15:0] cnt_r;
   logic        lvl_r;
   always_ff @(posedge clk) begin
      if (!run) begin
         cnt_r <= 16'h0;
         lvl_r <= 1'b0;
      end else if (cnt_r >= half - 16'h1) begin
         cnt_r <= 16'h0;
         lvl_r <= ~lvl_r;
      end else begin
         cnt_r <= cnt_r + 16'h1;
      end
   end
   // Glitch mode leaves only a short high pulse, shorter than the device filter
   assign pin = blink_oe ? 1'b0 : (lvl_r & (!glitch || cnt_r < 16'h28));
endmodule : fsio_mcu_model

// [tb/fsio_top_tb.sv]
// Self-checking bench for the fail outputs and heartbeat supervision.
// Assumes the heartbeat model drives the shared pin; reads are scored by a monitor.
`timescale 1ns/1ns
module fsio_top_tb;
   import fsio_pkg::*;
   logic          clk = 1'b0;
   logic          reset = 1'b1;
   logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]    paddr = 8'h0;
   logic [31:0]   pwdata = 32'h0, prdata;
   logic          pready, pslverr;
   fsio_mode_type mode = MODE_INIT;
   logic          watchdog_failure_bits_event = 1'b0, wd_trigger_ok = 1'b0;
   logic [2:0]    flt = 3'h0;
   logic          hb_pin, run = 1'b0, glitch = 1'b0;
   logic [15:0]   half = 16'hc8;
   logic          so_oe, bl_oe, pw_oe, so_pu, bl_pu, pw_pu;
   logic [32:0]   exp_q[$];
   logic [31:0]   msk_q[$];
   int            err_total = 0, total_checks = 0, seed = 32'h1517d444, bc, pc;
   always #5 clk = ~clk;
   fsio_top #(.HB_WINDOW(1000), .BLINK_HALF(20), .PWM_PERIOD(50), .PWM_LOW(10)) dut_u (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mode(mode), .watchdog_failure_bits_event(watchdog_failure_bits_event), .wd_trigger_ok(wd_trigger_ok),
      .thermal_shutdown_level2(flt[FI_THERMAL_SHUTDOWN_LEVEL2]), .main_regulator_short(flt[FI_VCC_SHORT]),
      .reset_output_clamped(flt[FI_RO_CLAMP]), .safety_heartbeat_in(hb_pin),
      .fail_out_static_oe(so_oe), .fail_out_blink_oe(bl_oe), .fail_out_dim_pwm_oe(pw_oe),
      .fail_out_static_pu(so_pu), .fail_out_blink_pu(bl_pu), .fail_out_dim_pwm_pu(pw_pu));
   fsio_mcu_model mcu_u (.clk(clk), .run(run), .glitch(glitch), .half(half),
      .blink_oe(bl_oe), .pin(hb_pin));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic [31:0] m, input logic se);
      if (!w) begin
         exp_q.push_back({se, e});
         msk_q.push_back(m);
      end
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No wait-state count is assumed; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wd_pulse(input logic trig);
      @(posedge clk);
      if (trig) wd_trigger_ok <= 1'b1;
      else watchdog_failure_bits_event <= 1'b1;
      @(posedge clk);
      wd_trigger_ok <= 1'b0;
      watchdog_failure_bits_event <= 1'b0;
   endtask : wd_pulse
   task automatic pu_check(input logic [2:0] e);
      repeat (3) @(posedge clk);
      check("pull_ups", {29'h0, so_pu, bl_pu, pw_pu}, {29'h0, e});
   endtask : pu_check
   // Read results are scored here, oldest expectation first
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
         check("prdata", prdata & msk_q[0], exp_q[0][31:0]);
         check("pslverr", {31'h0, pslverr}, {31'h0, exp_q[0][32]});
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      check("oe_reset", {29'h0, so_oe, bl_oe, pw_oe}, 32'h0);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h0, 32'hf, 1'b0);
      apb(1'b0, ADDR_HARDWARE_CONTROL_REG, 32'h0, 32'h0, 32'h3, 1'b0);
      apb(1'b1, 8'h0c, $random(seed), 32'h0, 32'h0, 1'b0);
      apb(1'b0, 8'h0c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
      pu_check(3'b111);
      for (int i = 0; i < 3; i++) begin
         repeat ($random(seed) & 7) @(posedge clk);
         flt <= 3'h1 << i;
         repeat (4) @(posedge clk);
         check("static_oe", {31'h0, so_oe}, 32'h1);
         apb(1'b0, ADDR_FAIL_IN, 32'h0, 32'h1 << i, 32'h7, 1'b0);
         apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h1, 32'h1, 1'b0);
         bc = 0;
         pc = 0;
         repeat (200) begin
            @(posedge clk);
            bc += bl_oe;
            pc += pw_oe;
         end
         check("blink_time", bc, 100);
         check("pwm_time", pc, 40);
         apb(1'b1, ADDR_DEVICE_STATUS_REG, 32'h1, 32'h0, 32'h0, 1'b0);
         apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h1, 32'h1, 1'b0);
         flt <= 3'h0;
         apb(1'b1, ADDR_DEVICE_STATUS_REG, 32'h1, 32'h0, 32'h0, 1'b0);
         apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h0, 32'h1, 1'b0);
         repeat (4) @(posedge clk);
         check("oe_off", {29'h0, so_oe, bl_oe, pw_oe}, 32'h0);
      end
      apb(1'b1, ADDR_HARDWARE_CONTROL_REG, 32'h1, 32'h0, 32'h0, 1'b0);
      wd_pulse(1'b0);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h4, 32'hf, 1'b0);
      wd_pulse(1'b0);
      // The failure bits fill from the low end, so two failures read as 2'b11
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'hd, 32'hf, 1'b0);
      apb(1'b1, ADDR_DEVICE_STATUS_REG, 32'h1, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h1, 32'h1, 1'b0);
      for (int k = 0; k < 2; k++) begin
         // Bits cleared but no successful trigger yet: the clear is refused
         apb(1'b1, ADDR_DEVICE_STATUS_REG, 32'h4, 32'h0, 32'h0, 1'b0);
         apb(1'b1, ADDR_DEVICE_STATUS_REG, 32'h1, 32'h0, 32'h0, 1'b0);
         apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h1, 32'hf, 1'b0);
         wd_pulse(1'b1);
         apb(1'b1, ADDR_DEVICE_STATUS_REG, 32'h1, 32'h0, 32'h0, 1'b0);
         apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h0, 32'hf, 1'b0);
         apb(1'b1, ADDR_HARDWARE_CONTROL_REG, 32'h0, 32'h0, 32'h0, 1'b0);
         if (k == 0) begin
            wd_pulse(1'b0);
            apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h1, 32'h1, 1'b0);
         end
      end
      mode <= MODE_NORMAL;
      half <= 16'hc8 + 16'($unsigned($random(seed)) % 50);
      run <= 1'b1;
      pu_check(3'b110);
      repeat (3000) @(posedge clk);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h0, 32'h2, 1'b0);
      glitch <= 1'b1;
      repeat (2500) @(posedge clk);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h2, 32'h2, 1'b0);
      // The dimmed output is a waveform, so it is judged over one whole period
      pc = 0;
      repeat (50) begin
         @(posedge clk);
         pc += pw_oe;
      end
      check("hb_static_blink_oe", {30'h0, so_oe, bl_oe}, 32'h2);
      check("hb_pwm_time", pc, 10);
      apb(1'b1, ADDR_DEVICE_STATUS_REG, 32'h2, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h2, 32'h2, 1'b0);
      glitch <= 1'b0;
      repeat (700) @(posedge clk);
      apb(1'b1, ADDR_DEVICE_STATUS_REG, 32'h2, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h0, 32'h2, 1'b0);
      apb(1'b1, ADDR_HARDWARE_CONTROL_REG, 32'h2, 32'h0, 32'h0, 1'b0);
      pu_check(3'b100);
      run <= 1'b0;
      repeat (2500) @(posedge clk);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h0, 32'h2, 1'b0);
      mode <= MODE_INIT;
      apb(1'b1, ADDR_HARDWARE_CONTROL_REG, 32'h0, 32'h0, 32'h0, 1'b0);
      repeat (2500) @(posedge clk);
      apb(1'b0, ADDR_DEVICE_STATUS_REG, 32'h0, 32'h0, 32'h2, 1'b0);
      mode <= MODE_STOP;
      pu_check(3'b000);
      complete_run();
   end
endmodule : fsio_top_tb
